// >>> bqd_defs.svh
/*
 * Register offsets, field positions, reset values and watchdog command
 * codes for the self-test, watchdog status and transistor-test registers.
 * Assumes the serial front end hands over decoded 8-bit addresses and
 * 16-bit data words.
 */
`ifndef BQD_DEFS_SVH
`define BQD_DEFS_SVH

// ----------------------------------------------------------------------
// addresses
// ----------------------------------------------------------------------
`define BQD_WR_ANSWER 8'h50
`define BQD_WR_DIAG 8'h54
`define BQD_WR_FET 8'h5C
`define BQD_RD_QA 8'hD0
`define BQD_RD_DIAG 8'hD4
`define BQD_RD_STAT 8'hD8
`define BQD_RD_FET 8'hDC

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BQD_DIAG_FORCE 0
`define BQD_DIAG_RESTART 4
`define BQD_ST_AEND 0
`define BQD_ST_APASS 1
`define BQD_ST_LEND 4
`define BQD_ST_LPASS 5
`define BQD_FET_STOP 0
`define BQD_FET_START 1
`define BQD_FET_TYPE_LO 2
`define BQD_FET_CMP_SEL 4
`define BQD_FET_NDG_SEL 5
`define BQD_FET_CLR 7
`define BQD_FET_MID_LO 8
`define BQD_FET_MANUAL 11

// ----------------------------------------------------------------------
// reset values and command codes
// ----------------------------------------------------------------------
`define BQD_PREV_EXP_RST 4'hF
`define BQD_CNT_MAX 4'hF
`define BQD_CMD_STOP 4'h5
`define BQD_CMD_ANSWER 4'h7
`define BQD_CMD_START 4'hA

`endif

// >>> bqd_pkg.sv
/*
 * Types shared by the self-test and watchdog status register bank.
 * Assumes bqd_defs.svh supplies the numeric command codes.
 */
`include "bqd_defs.svh"

package bqd_pkg;

    // logic self-test progress as seen by the register bank
    typedef enum logic [1:0] {
        BQD_LB_IDLE = 2'b00,
        BQD_LB_RUN = 2'b01,
        BQD_LB_DONE = 2'b10
    } bqd_lbist_t;

    typedef enum logic [3:0] {
        BQD_QA_STOP = `BQD_CMD_STOP,
        BQD_QA_ANSWER = `BQD_CMD_ANSWER,
        BQD_QA_START = `BQD_CMD_START
    } bqd_qa_cmd_t;

endpackage

// >>> bqd_qa_status.sv
/*
 * Watchdog question-answer status tracker: error count, sequence number
 * and previous expected answer. Assumes the watchdog engine supplies the
 * sequence number, expected answer loads and its own error events.
 */
`timescale 1ns/10ps
`include "bqd_defs.svh"

module bqd_qa_status (
    input wire logic clock,           // system clock
    input wire logic rstn,            // async reset, active low
    input wire logic cmd_wr,          // command word written, pulse
    input wire logic [3:0] cmd_code,  // written command code
    input wire logic [3:0] seq_in,    // engine sequence number
    input wire logic exp_load,        // expected answer update, pulse
    input wire logic [3:0] exp_in,    // expected answer value
    input wire logic err_inc,         // engine error event, pulse
    output logic [3:0] err_count,     // accumulated errors
    output logic [3:0] seq_num,       // current sequence number
    output logic [3:0] prev_exp,      // previous expected answer
    output logic qa_active            // sequence running
);

    logic [3:0] err_count_nxt;
    logic bad_code;

    // saturating step, shared by both error sources
    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        if (v == `BQD_CNT_MAX) begin
            return v;
        end
        return v + 4'h1;
    endfunction

    assign bad_code = cmd_wr && qa_active &&
        (cmd_code != bqd_pkg::BQD_QA_STOP) &&
        (cmd_code != bqd_pkg::BQD_QA_ANSWER) &&
        (cmd_code != bqd_pkg::BQD_QA_START);

    // ------------------------------------------------------------------
    // sequence activity
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            qa_active <= 1'b0;
        end else if (cmd_wr && cmd_code == bqd_pkg::BQD_QA_START) begin
            qa_active <= 1'b1;
        end else if (cmd_wr && cmd_code == bqd_pkg::BQD_QA_STOP) begin
            qa_active <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // error count, saturating so it never wraps back to a clean value
    // ------------------------------------------------------------------
    always_comb begin
        err_count_nxt = err_count;
        if (bad_code) begin
            err_count_nxt = sat_inc(err_count_nxt);
        end
        if (err_inc) begin
            err_count_nxt = sat_inc(err_count_nxt);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            err_count <= 4'h0;
        end else begin
            err_count <= err_count_nxt;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            seq_num <= 4'h0;
        end else begin
            seq_num <= seq_in;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_exp <= `BQD_PREV_EXP_RST;
        end else if (exp_load) begin
            prev_exp <= exp_in;
        end
    end

endmodule // bqd_qa_status

// >>> bqd_regs.sv
/*
 * Self-test control and status, watchdog status and transistor-test
 * control registers. Assumes the serial front end delivers one-cycle
 * write and read strobes with decoded addresses, and that the self-test
 * engines report start, completion and pass/fail as one-cycle pulses.
 */
`timescale 1ns/10ps
`include "bqd_defs.svh"

module bqd_regs (
    input wire logic clock,             // 125 MHz system clock
    input wire logic rstn,              // async reset, active low
    input wire logic wr_en,             // register write strobe
    input wire logic [7:0] wr_addr,     // write address
    input wire logic [15:0] wr_data,    // write data
    input wire logic rd_en,             // register read strobe
    input wire logic [7:0] rd_addr,     // read address
    output logic [15:0] rd_data,        // read data, registered
    output logic rd_valid,              // read data valid, pulse
    output logic serial_busy,           // serial access refused
    input wire logic [3:0] qa_seq_in,   // watchdog sequence number
    input wire logic qa_exp_load,       // expected answer update
    input wire logic [3:0] qa_exp_in,   // expected answer value
    input wire logic qa_err_inc,        // watchdog engine error
    output logic qa_active,             // watchdog sequence running
    input wire logic lbist_start,       // logic self-test starts
    input wire logic lbist_done,        // logic self-test completes
    input wire logic lbist_pass,        // logic self-test verdict
    input wire logic abist_start,       // analog self-test starts
    input wire logic abist_done,        // analog self-test completes
    input wire logic abist_pass,        // analog self-test verdict
    output logic bist_restart_req,      // restart wanted, level
    input wire logic bist_restart_go,   // restart begins, pulse
    input wire logic fault_n_in,        // fault indicator from monitors
    output logic fault_n_out,           // fault indicator pin, low active
    input wire logic fet_test_unlock,   // transistor test unlocked
    output logic manual_test,           // manual transistor test mode
    output logic phase_a_midpoint_resistor_on, // phase a resistors
    output logic phase_b_midpoint_resistor_on, // phase b resistors
    output logic phase_c_midpoint_resistor_on, // phase c resistors
    output logic check_fault_output_select,    // fault out during test
    output logic comparator_readback_select,   // live comparator read
    output logic [1:0] fet_test_type,   // test type a to d
    output logic saved_result_clear,    // clear saved results, pulse
    output logic fet_test_start,        // start sequence, pulse
    output logic fet_test_stop          // stop sequence, pulse
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    bqd_pkg::bqd_lbist_t lb_state_r;
    logic lbst_end_r, lbst_flag_r, abst_end_r, abst_flag_r;
    logic restart_r, force_r;
    logic [15:0] fet_r;
    logic [15:0] rd_nxt;
    logic wr_ok, rd_ok, bist_failed;
    logic wr_diag, wr_fet, wr_answer;
    logic [3:0] qa_err, qa_seq, qa_prev;

    assign serial_busy = (lb_state_r == bqd_pkg::BQD_LB_RUN);
    assign wr_ok = wr_en && !serial_busy;
    assign rd_ok = rd_en && !serial_busy;

    always_comb begin
        wr_diag = 1'b0;
        wr_fet = 1'b0;
        wr_answer = 1'b0;
        if (wr_ok && wr_addr == `BQD_WR_DIAG) begin
            wr_diag = 1'b1;
        end else if (wr_ok && wr_addr == `BQD_WR_FET) begin
            wr_fet = 1'b1;
        end else if (wr_ok && wr_addr == `BQD_WR_ANSWER) begin
            wr_answer = 1'b1;
        end
    end

    bqd_qa_status u_qa (
        .clock(clock),
        .rstn(rstn),
        .cmd_wr(wr_answer),
        .cmd_code(wr_data[7:4]),
        .seq_in(qa_seq_in),
        .exp_load(qa_exp_load),
        .exp_in(qa_exp_in),
        .err_inc(qa_err_inc),
        .err_count(qa_err),
        .seq_num(qa_seq),
        .prev_exp(qa_prev),
        .qa_active(qa_active)
    );

    // ------------------------------------------------------------------
    // logic and analog self-test tracking
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lb_state_r <= bqd_pkg::BQD_LB_IDLE;
        end else begin
            case (lb_state_r)
                bqd_pkg::BQD_LB_IDLE: begin
                    if (lbist_start) begin
                        lb_state_r <= bqd_pkg::BQD_LB_RUN;
                    end
                end
                bqd_pkg::BQD_LB_RUN: begin
                    if (lbist_done) begin
                        lb_state_r <= bqd_pkg::BQD_LB_DONE;
                    end
                end
                bqd_pkg::BQD_LB_DONE: begin
                    if (lbist_start) begin
                        lb_state_r <= bqd_pkg::BQD_LB_RUN;
                    end
                end
                default: begin
                    lb_state_r <= bqd_pkg::BQD_LB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lbst_end_r <= 1'b0;
            abst_end_r <= 1'b0;
        end else begin
            if (lbist_done) begin
                lbst_end_r <= 1'b1;
            end else if (lbist_start) begin
                lbst_end_r <= 1'b0;
            end
            if (abist_done) begin
                abst_end_r <= 1'b1;
            end else if (abist_start) begin
                abst_end_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lbst_flag_r <= 1'b0;
            abst_flag_r <= 1'b0;
        end else begin
            if (lbist_done) begin
                lbst_flag_r <= lbist_pass;
            end
            if (abist_done) begin
                abst_flag_r <= abist_pass;
            end
        end
    end

    assign bist_failed = (lbst_end_r && !lbst_flag_r) ||
        (abst_end_r && !abst_flag_r);

    // ------------------------------------------------------------------
    // restart request and fault force
    // ------------------------------------------------------------------
    // a written one while both tests pass is dropped, so it cannot
    // linger and fire later after an unrelated failure
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            restart_r <= 1'b0;
        end else if (wr_diag && wr_data[`BQD_DIAG_RESTART] &&
                     bist_failed) begin
            restart_r <= 1'b1;
        end else if (bist_restart_go) begin
            restart_r <= 1'b0;
        end
    end
    assign bist_restart_req = restart_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            force_r <= 1'b0;
        end else if (wr_diag) begin
            force_r <= wr_data[`BQD_DIAG_FORCE];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fault_n_out <= 1'b1;
        end else begin
            fault_n_out <= fault_n_in && !force_r;
        end
    end

    // ------------------------------------------------------------------
    // transistor-test control
    // ------------------------------------------------------------------
    // field store, lock-gated bits
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fet_r <= 16'h0000;
        end else if (wr_fet) begin
            fet_r[`BQD_FET_TYPE_LO +: 2] <= wr_data[`BQD_FET_TYPE_LO +: 2];
            fet_r[`BQD_FET_CMP_SEL] <= wr_data[`BQD_FET_CMP_SEL];
            fet_r[`BQD_FET_NDG_SEL] <= wr_data[`BQD_FET_NDG_SEL];
            if (fet_test_unlock) begin
                fet_r[`BQD_FET_MANUAL] <= wr_data[`BQD_FET_MANUAL];
                fet_r[`BQD_FET_MID_LO +: 3] <= wr_data[`BQD_FET_MID_LO +: 3];
            end
        end
    end

    // start, stop and clear are one-cycle strobes that read back zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fet_test_stop <= 1'b0;
            fet_test_start <= 1'b0;
            saved_result_clear <= 1'b0;
        end else begin
            fet_test_stop <= wr_fet && wr_data[`BQD_FET_STOP];
            fet_test_start <= wr_fet && wr_data[`BQD_FET_START] &&
                !wr_data[`BQD_FET_STOP] && fet_test_unlock;
            saved_result_clear <= wr_fet && wr_data[`BQD_FET_CLR];
        end
    end

    assign manual_test = fet_r[`BQD_FET_MANUAL];
    assign phase_a_midpoint_resistor_on = fet_r[`BQD_FET_MID_LO + 2];
    assign phase_b_midpoint_resistor_on = fet_r[`BQD_FET_MID_LO + 1];
    assign phase_c_midpoint_resistor_on = fet_r[`BQD_FET_MID_LO];
    assign check_fault_output_select = fet_r[`BQD_FET_NDG_SEL];
    assign comparator_readback_select = fet_r[`BQD_FET_CMP_SEL];
    assign fet_test_type = fet_r[`BQD_FET_TYPE_LO +: 2];

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // unassigned bits zero
    always_comb begin
        rd_nxt = 16'h0000;
        if (rd_addr == `BQD_RD_QA) begin
            rd_nxt[11:0] = {qa_err, qa_seq, qa_prev};
        end else if (rd_addr == `BQD_RD_DIAG) begin
            rd_nxt[`BQD_DIAG_FORCE] = force_r;
            rd_nxt[`BQD_DIAG_RESTART] = restart_r;
        end else if (rd_addr == `BQD_RD_STAT) begin
            rd_nxt[`BQD_ST_AEND] = abst_end_r;
            rd_nxt[`BQD_ST_APASS] = abst_flag_r;
            rd_nxt[`BQD_ST_LEND] = lbst_end_r;
            rd_nxt[`BQD_ST_LPASS] = lbst_flag_r;
        end else if (rd_addr == `BQD_RD_FET) begin
            rd_nxt = fet_r;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_ok;
            if (rd_ok) begin
                rd_data <= rd_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    force_low_a: assert property (
        wr_diag && wr_data[`BQD_DIAG_FORCE] |=> ##1 !fault_n_out)
        else $error("fault pin not forced low");
    restart_gate_a: assert property (
        $rose(restart_r) |-> $past(bist_failed) && $past(wr_diag))
        else $error("restart accepted without failure");
    restart_clear_a: assert property (
        restart_r && bist_restart_go && !wr_diag |=> !restart_r)
        else $error("restart request not cleared");
    lbist_end_a: assert property (
        lbist_done |=> lbst_end_r && lbst_flag_r == $past(lbist_pass))
        else $error("logic test end or verdict wrong");
    abist_end_a: assert property (
        abist_done |=> abst_end_r && abst_flag_r == $past(abist_pass))
        else $error("analog test end or verdict wrong");
    busy_end_a: assert property (
        serial_busy |-> !lbst_end_r ##1 !rd_valid)
        else $error("end flag set or read served while busy");
    qa_read_a: assert property (
        rd_ok && rd_addr == `BQD_RD_QA |=>
        rd_valid && rd_data[15:8] == {4'h0, $past(qa_err)})
        else $error("watchdog status read wrong");
    fet_stop_a: assert property (
        wr_fet && wr_data[`BQD_FET_STOP] |=> fet_test_stop && !fet_test_start)
        else $error("stop did not take priority");
    fet_lock_a: assert property (
        wr_fet && !fet_test_unlock |=> $stable(fet_r[11:8]) && !fet_test_start)
        else $error("locked bits changed");
    stat_zero_a: assert property (
        rd_valid && $past(rd_addr) == `BQD_RD_STAT |->
        rd_data[15:6] == 10'h000)
        else $error("reserved status bits not zero");

    restart_c: cover property (restart_r ##[1:20] bist_restart_go);
    lbist_c: cover property (lbist_start ##[1:50] lbist_done);
    force_c: cover property (wr_diag ##2 !fault_n_out);
    fet_c: cover property (fet_test_start);

endmodule // bqd_regs

// >>> bqd_host_model.sv
/* Host side of the register strobes: one-cycle writes and reads.
   Assumes the clock shared with the register bank. */
`timescale 1ns/10ps

module bqd_host_model (
    input wire logic clock,          // system clock
    output logic wr_en,              // write strobe
    output logic [7:0] wr_addr,      // write address
    output logic [15:0] wr_data,     // write data
    output logic rd_en,              // read strobe
    output logic [7:0] rd_addr,      // read address
    input wire logic [15:0] rd_data, // read data
    input wire logic rd_valid        // read answer
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_addr = 8'h00;
        wr_data = 16'h0000;
        rd_addr = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask

    // answer one cycle on, or none while busy
    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic v);
        @(posedge clock);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        rd_addr <= ~a;
        // answer launched by the request edge, sampled at the next edge
        @(posedge clock);
        v = rd_valid;
        d = rd_data;
    endtask
endmodule // bqd_host_model

// >>> tb_top.sv
/* Self-checking bench for bqd_regs driven through the host model.
   Assumes the register bank answers reads exactly one cycle late. */
`timescale 1ns/10ps

module tb_top;
    logic clock, rstn, wr_en, rd_en, rd_valid, serial_busy, qa_active;
    logic [7:0] wr_addr, rd_addr;
    logic [15:0] wr_data, rd_data, v16;
    logic [3:0] qa_seq_in, qa_exp_in;
    logic [6:0] pv;
    logic lbist_pass, abist_pass, bist_restart_req, fault_n_in;
    logic fault_n_out, fet_test_unlock, vld;
    logic [8:0] fo;
    logic [1:0] fet_test_type;
    int err_count, tests_run, cyc;

    bqd_host_model host_u (.clock(clock), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

    bqd_regs dut_u (.clock(clock), .rstn(rstn), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .serial_busy(serial_busy), .qa_seq_in(qa_seq_in),
        .qa_exp_load(pv[1]), .qa_exp_in(qa_exp_in), .qa_err_inc(pv[0]),
        .qa_active(qa_active), .lbist_start(pv[2]), .lbist_done(pv[3]),
        .lbist_pass(lbist_pass), .abist_start(pv[4]),
        .abist_done(pv[5]), .abist_pass(abist_pass),
        .bist_restart_req(bist_restart_req), .bist_restart_go(pv[6]),
        .fault_n_in(fault_n_in), .fault_n_out(fault_n_out),
        .fet_test_unlock(fet_test_unlock), .manual_test(fo[8]),
        .phase_a_midpoint_resistor_on(fo[7]),
        .phase_b_midpoint_resistor_on(fo[6]),
        .phase_c_midpoint_resistor_on(fo[5]),
        .check_fault_output_select(fo[4]),
        .comparator_readback_select(fo[3]), .fet_test_type(fet_test_type),
        .saved_result_clear(fo[2]), .fet_test_start(fo[1]),
        .fet_test_stop(fo[0]));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [16:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        host_u.rd(a, v16, vld);
        chk("read", {vld, v16}, {1'b1, e});
    endtask

    // one-cycle pulse on an engine input
    task automatic pl(input int k);
        @(posedge clock);
        pv[k] <= 1'b1;
        @(posedge clock);
        pv <= 7'h00;
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // hang guard: the sequence needs well under 300 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        pv = 7'h00;
        qa_seq_in = 4'h0;
        qa_exp_in = 4'h0;
        lbist_pass = 1'b0;
        abist_pass = 1'b1;
        fault_n_in = 1'b1;
        fet_test_unlock = 1'b0;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        rdc(8'hD0, 16'h000F);
        rdc(8'hD8, 16'h0000);
        rdc(8'hD4, 16'h0000);
        rdc(8'hDC, 16'h0000);
        rdc(8'hE4, 16'h0000);
        qa_seq_in <= 4'h5;
        qa_exp_in <= 4'h3;
        host_u.wr(8'h50, 16'h00A0);
        #1;
        chk("qa_active", {16'h0, qa_active}, 17'h1);
        host_u.wr(8'h50, 16'h0030);
        pl(0);
        pl(1);
        rdc(8'hD0, 16'h0253);
        host_u.wr(8'h50, 16'h0050);
        host_u.wr(8'h50, 16'h0030);
        rdc(8'hD0, 16'h0253);
        host_u.wr(8'h54, 16'h0011);
        @(posedge clock);
        #1;
        chk("fault_n_out", {16'h0, fault_n_out}, 17'h0);
        rdc(8'hD4, 16'h0001);
        host_u.wr(8'h54, 16'h0000);
        @(posedge clock);
        #1;
        chk("fault_n_out", {16'h0, fault_n_out}, 17'h1);
        pl(2);
        chk("serial_busy", {16'h0, serial_busy}, 17'h1);
        host_u.rd(8'hD8, v16, vld);
        chk("refused", {16'h0, vld}, 17'h0);
        pl(3);
        pl(4);
        pl(5);
        rdc(8'hD8, 16'h0013);
        host_u.wr(8'h54, 16'h0010);
        #1;
        chk("restart", {16'h0, bist_restart_req}, 17'h1);
        rdc(8'hD4, 16'h0010);
        pl(6);
        chk("restart", {16'h0, bist_restart_req}, 17'h0);
        pl(4);
        rdc(8'hD8, 16'h0012);
        // locked: gated bits and start must not take effect
        host_u.wr(8'h5C, 16'h0F02);
        #1;
        chk("locked start", {16'h0, fo[1]}, 17'h0);
        rdc(8'hDC, 16'h0000);
        fet_test_unlock <= 1'b1;
        host_u.wr(8'h5C, 16'h0FBE);
        #1;
        chk("fet", {6'h00, fet_test_type, fo}, 17'h007FE);
        rdc(8'hDC, 16'h0F3C);
        host_u.wr(8'h5C, 16'h0003);
        #1;
        chk("fet_stop", {15'h0, fo[1:0]}, 17'h1);
        host_u.wr(8'h58, 16'hFFFF);
        rdc(8'hD8, 16'h0012);
        conclude();
    end
endmodule // tb_top
